// ### evt_timer.sv
// event timer with double-buffered reload, buzzer toggle and pwm output
// assumes apb master on clk_i, event pin asynchronous (two-flop synchronized), fast osc tick synchronous
`timescale 1ns/10ps
module evt_timer
    import evt_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // clock sources
    input wire logic fast_osc_tick_i,
    input wire logic external_event_input_i,
    // requests
    output logic overflow_request_o,
    output logic edge_pin_request_o,
    output logic irq_o,
    // shared pin
    output logic toggle_pin_o,
    output logic toggle_pin_oe_o
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic [7:0] boundary_top(input logic pwm, input logic [1:0] sel);
        logic [7:0] top;
        top = TOP_256;
        if (pwm)
        begin
            case (sel)
                2'b01: top = TOP_64;
                2'b10: top = TOP_32;
                2'b11: top = TOP_16;
                default: top = TOP_256;
            endcase
        end
        return top;
    endfunction : boundary_top

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction : hit

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] mode_ff;
    logic [7:0] base_ff;
    logic [7:0] count_ff;
    logic [7:0] reload_buf_ff;
    logic [7:0] reload_act_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] irq_en_ff;
    logic [31:0] prdata_ff;
    logic err_ff;
    logic [7:0] pre_cnt_ff;
    logic hosc_half_ff;
    logic ev_sync1_ff;
    logic ev_sync2_ff;
    logic ev_prev_ff;
    logic toggle_ff;
    logic pin_ff;
    logic oe_ff;

    // ----------------------------------------
    // apb access
    // ----------------------------------------
    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic wr_mode;
    logic wr_base;
    logic wr_count;
    logic wr_reload;
    logic wr_clear;
    logic wr_enable;
    logic [31:0] nxt_prdata;

    assign setup_ph = psel_i && !penable_i;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign mapped = hit(paddr_i, IDX_RELOAD_VALUE) || hit(paddr_i, IDX_BASE_MODE)
        || hit(paddr_i, IDX_MODE_CONTROL) || hit(paddr_i, IDX_COUNT)
        || hit(paddr_i, IDX_IRQ_STATUS) || hit(paddr_i, IDX_IRQ_CLEAR)
        || hit(paddr_i, IDX_IRQ_ENABLE);
    assign wr_mode = wr_acc && hit(paddr_i, IDX_MODE_CONTROL);
    assign wr_base = wr_acc && hit(paddr_i, IDX_BASE_MODE);
    assign wr_count = wr_acc && hit(paddr_i, IDX_COUNT);
    assign wr_reload = wr_acc && hit(paddr_i, IDX_RELOAD_VALUE);
    assign wr_clear = wr_acc && hit(paddr_i, IDX_IRQ_CLEAR);
    assign wr_enable = wr_acc && hit(paddr_i, IDX_IRQ_ENABLE);

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (hit(paddr_i, IDX_BASE_MODE))
            nxt_prdata[7:0] = base_ff;
        else if (hit(paddr_i, IDX_MODE_CONTROL))
            nxt_prdata[7:0] = mode_ff;
        else if (hit(paddr_i, IDX_COUNT))
            nxt_prdata[7:0] = count_ff;
        else if (hit(paddr_i, IDX_IRQ_STATUS))
            nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
        else if (hit(paddr_i, IDX_IRQ_ENABLE))
            nxt_prdata[IRQ_W-1:0] = irq_en_ff;
    end

    // read data and error captured in setup, answered in access
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_ff <= nxt_prdata;
            err_ff <= !mapped;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && err_ff;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode_ff <= RST_REG;
            base_ff <= RST_REG;
            irq_en_ff <= '0;
        end
        else
        begin
            if (wr_mode)
                mode_ff <= pwdata_i[7:0];
            if (wr_base)
                base_ff <= pwdata_i[7:0] & BM_WR_MASK;
            if (wr_enable)
                irq_en_ff <= pwdata_i[IRQ_W-1:0];
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    logic run_en;
    logic ext_sel;
    logic pwm_en;
    logic tog_en;
    logic aload_en;
    logic [2:0] rate;
    logic [7:0] top;

    assign run_en = mode_ff[MC_RUN_BIT];
    assign ext_sel = mode_ff[MC_SRC_BIT];
    assign pwm_en = mode_ff[MC_PWM_BIT];
    assign tog_en = mode_ff[MC_TOG_BIT];
    assign aload_en = mode_ff[MC_ALOAD_BIT];
    assign rate = mode_ff[MC_RATE_HI:MC_RATE_LO];
    assign top = boundary_top(pwm_en, {aload_en, tog_en});

    // ----------------------------------------
    // clock sources
    // ----------------------------------------
    logic fcpu_tick;
    logic hosc_tick;
    logic ev_fall;
    logic src_tick;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pre_cnt_ff <= RST_REG;
        else
            pre_cnt_ff <= pre_cnt_ff + COUNT_ONE;
    end

    // divisor 256 >> rate
    assign fcpu_tick = (pre_cnt_ff & (PRE_FULL >> rate)) == (PRE_FULL >> rate);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            hosc_half_ff <= 1'b0;
        else if (fast_osc_tick_i)
            hosc_half_ff <= !hosc_half_ff;
    end

    assign hosc_tick = fast_osc_tick_i && (base_ff[BM_DIV_BIT] || hosc_half_ff);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ev_sync1_ff <= 1'b1;
            ev_sync2_ff <= 1'b1;
            ev_prev_ff <= 1'b1;
        end
        else
        begin
            ev_sync1_ff <= external_event_input_i;
            ev_sync2_ff <= ev_sync1_ff;
            ev_prev_ff <= ev_sync2_ff;
        end
    end

    assign ev_fall = ev_prev_ff && !ev_sync2_ff;

    always_comb
    begin
        if (ext_sel)
            src_tick = ev_fall;
        else if (base_ff[BM_OVR_BIT])
            src_tick = hosc_tick;
        else
            src_tick = fcpu_tick;
    end

    // ----------------------------------------
    // counter and reload buffers
    // ----------------------------------------
    logic cnt_tick;
    logic ovf;

    assign cnt_tick = run_en && src_tick;
    assign ovf = cnt_tick && ((count_ff & top) == top);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            count_ff <= RST_REG;
        else if (wr_count)
            count_ff <= pwdata_i[7:0];
        else if (ovf && pwm_en)
            count_ff <= RST_REG;
        else if (ovf && aload_en)
            count_ff <= reload_act_ff;
        else if (cnt_tick)
            count_ff <= count_ff + COUNT_ONE;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            reload_buf_ff <= RST_REG;
            reload_act_ff <= RST_REG;
        end
        else
        begin
            if (wr_reload)
                reload_buf_ff <= pwdata_i[7:0];
            if (ovf)
                reload_act_ff <= reload_buf_ff;
        end
    end

    // ----------------------------------------
    // interrupt flags, set wins over clear
    // ----------------------------------------
    logic [IRQ_W-1:0] set_vec;
    logic edge_req_set;

    assign edge_req_set = ev_fall && !ext_sel;
    assign set_vec = {edge_req_set, ovf};

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_stat_ff <= '0;
        else
        begin
            for (int i = 0; i < IRQ_W; i++)
            begin
                if (set_vec[i])
                    irq_stat_ff[i] <= 1'b1;
                else if (wr_clear && pwdata_i[i])
                    irq_stat_ff[i] <= 1'b0;
            end
            if (ext_sel)
                irq_stat_ff[IRQ_EDGE_BIT] <= 1'b0;
        end
    end

    assign overflow_request_o = irq_stat_ff[IRQ_OVF_BIT];
    assign edge_pin_request_o = irq_stat_ff[IRQ_EDGE_BIT];
    assign irq_o = |(irq_stat_ff & irq_en_ff);

    // ----------------------------------------
    // buzzer toggle and pwm pin
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            toggle_ff <= 1'b0;
        else if (ovf)
            toggle_ff <= !toggle_ff;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
        end
        else if (pwm_en)
        begin
            pin_ff <= (count_ff & top) < (reload_act_ff & top);
            oe_ff <= 1'b1;
        end
        else
        begin
            pin_ff <= tog_en && toggle_ff;
            oe_ff <= tog_en;
        end
    end

    assign toggle_pin_o = pin_ff;
    assign toggle_pin_oe_o = oe_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_overflow_sets_flag: assert property (ovf |=> overflow_request_o)
        else $error("overflow did not set request");
    a_count_stops: assert property (!run_en && !wr_count |=> $stable(count_ff))
        else $error("counter moved while stopped");
    a_ext_edge_count: assert property (ext_sel && cnt_tick && !ovf && !wr_count
        |=> count_ff == $past(count_ff) + COUNT_ONE)
        else $error("event edge not counted");
    a_fast_rate: assert property (!ext_sel && !base_ff[BM_OVR_BIT] && rate == 3'h7
        && fcpu_tick && !wr_mode ##1 !wr_mode |-> !fcpu_tick ##1 fcpu_tick)
        else $error("divide by two rate wrong");
    a_reload_move: assert property (ovf |=> reload_act_ff == $past(reload_buf_ff))
        else $error("active reload not moved at overflow");
    a_reload_hold: assert property (!ovf |=> $stable(reload_act_ff))
        else $error("active reload changed mid period");
    a_auto_reload: assert property (ovf && !pwm_en && aload_en && !wr_count
        |=> count_ff == $past(reload_act_ff))
        else $error("auto reload missed");
    a_pwm_wrap: assert property (ovf && pwm_en && !wr_count |=> count_ff == RST_REG)
        else $error("pwm boundary wrap wrong");
    a_toggle_flip: assert property (ovf |=> toggle_ff != $past(toggle_ff))
        else $error("toggle did not flip");
    a_edge_req_zero: assert property (ext_sel |=> !edge_pin_request_o)
        else $error("edge request raised in external mode");
    a_pin_gpio: assert property (!pwm_en && !tog_en |=> !toggle_pin_oe_o)
        else $error("pin driven in gpio mode");
    a_flag_sticky: assert property (overflow_request_o && !wr_clear
        |=> overflow_request_o)
        else $error("overflow flag dropped");

    c_pwm_overflow: cover property (pwm_en && ovf ##1 toggle_pin_oe_o);
    c_ext_count: cover property (ext_sel && run_en && ev_fall);
    c_reload_change: cover property (wr_reload ##[1:300] ovf);
    c_irq_raise: cover property (!irq_o ##1 irq_o);

endmodule : evt_timer

// ### evt_pkg.sv
// package for the event timer: register map, field positions, reset values
// assumes a 32-bit apb master; printed offsets are word indices
package evt_pkg;
    // ----------------------------------------
    // register indices and apb address width
    // ----------------------------------------
    localparam logic [7:0] IDX_RELOAD_VALUE = 8'hcd;
    localparam logic [7:0] IDX_BASE_MODE = 8'hd8;
    localparam logic [7:0] IDX_MODE_CONTROL = 8'hda;
    localparam logic [7:0] IDX_COUNT = 8'hdb;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'he0;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'he1;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'he2;
    localparam int ADDR_W = 10;
    // ----------------------------------------
    // mode control fields
    // ----------------------------------------
    localparam int MC_RUN_BIT = 7;
    localparam int MC_RATE_HI = 6;
    localparam int MC_RATE_LO = 4;
    localparam int MC_SRC_BIT = 3;
    localparam int MC_ALOAD_BIT = 2;
    localparam int MC_TOG_BIT = 1;
    localparam int MC_PWM_BIT = 0;
    // ----------------------------------------
    // base mode fields
    // ----------------------------------------
    localparam int BM_OVR_BIT = 2;
    localparam int BM_DIV_BIT = 1;
    localparam logic [7:0] BM_WR_MASK = 8'hfe;
    // ----------------------------------------
    // interrupt status bits
    // ----------------------------------------
    localparam int IRQ_W = 2;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_EDGE_BIT = 1;
    // ----------------------------------------
    // reset values and boundaries
    // ----------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] TOP_256 = 8'hff;
    localparam logic [7:0] TOP_64 = 8'h3f;
    localparam logic [7:0] TOP_32 = 8'h1f;
    localparam logic [7:0] TOP_16 = 8'h0f;
    localparam logic [7:0] PRE_FULL = 8'hff;
    localparam logic [7:0] COUNT_ONE = 8'h01;
endpackage : evt_pkg

// ### evt_partner.sv
// partner model: event pin driver and fast oscillator tick source
// assumes the bench calls its tasks from the clk_i domain
`timescale 1ns/10ps
module evt_partner
(
    // clock
    input wire logic clk_i,
    // pins toward the timer
    output logic event_o,
    output logic tick_o
);
    initial
    begin
        event_o = 1'b1;
        tick_o = 1'b0;
    end
    // falling edges on the event pin, idles high
    task automatic pulse_events(input int n);
        repeat (n)
        begin
            @(posedge clk_i) event_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            event_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask : pulse_events
    // one-cycle oscillator ticks, one every two cycles
    task automatic send_ticks(input int n);
        repeat (n)
        begin
            @(posedge clk_i) tick_o <= 1'b1;
            @(posedge clk_i) tick_o <= 1'b0;
        end
    endtask : send_ticks
endmodule : evt_partner

// ### event_timer_with_reload_tb_top.sv
// testbench for the event timer: apb master, partner drives pin and ticks
// assumes the apb slave answers within the watchdog span
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module event_timer_with_reload_tb_top
    import evt_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_n_i;
    logic psel_i;
    logic penable_i;
    logic pwrite_i;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, overflow_request_o, edge_pin_request_o, irq_o;
    logic toggle_pin_o, toggle_pin_oe_o, ev, tick, err_seen, t0;
    logic [31:0] rd;
    logic [31:0] seed = 32'hc7d49742;
    logic [7:0] v, top;
    int err_count = 0;
    int tests_run = 0;
    always #25 clk_i = ~clk_i;
    evt_timer evt_timer_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .fast_osc_tick_i(tick), .external_event_input_i(ev),
        .overflow_request_o(overflow_request_o), .edge_pin_request_o(edge_pin_request_o),
        .irq_o(irq_o), .toggle_pin_o(toggle_pin_o), .toggle_pin_oe_o(toggle_pin_oe_o));
    evt_partner evt_partner_i (.clk_i(clk_i), .event_o(ev), .tick_o(tick));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    function automatic logic [7:0] bnd_top(input int c);
        return (c == 0) ? 8'hff : (c == 1) ? 8'h3f : (c == 2) ? 8'h1f : 8'h0f;
    endfunction : bnd_top
    function automatic logic in_rng(input logic [7:0] x, input int lo, input int hi);
        return (int'(x) >= lo) && (int'(x) <= hi);
    endfunction : in_rng
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= wd;
        @(posedge clk_i) penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        err_seen = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h0, d});
    endtask : wr
    task automatic rdv(input logic [7:0] idx);
        apb(1'b0, idx, 32'h0);
    endtask : rdv
    task automatic give_verdict();
        $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        give_verdict();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        reset_n_i <= 1'b0;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        pwrite_i <= 1'b0;
        paddr_i <= '0;
        pwdata_i <= '0;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdv(IDX_COUNT);
        `CHK(rd, 32'h0)
        `CHK(pready_o, 1'b1)
        rdv(IDX_RELOAD_VALUE);
        `CHK(rd, 32'h0)
        wr(IDX_BASE_MODE, 8'hff);
        rdv(IDX_BASE_MODE);
        `CHK(rd[7:0], BM_WR_MASK)
        rdv(8'h10);
        `CHK(err_seen, 1'b1)
        evt_partner_i.pulse_events(1);
        `CHK(edge_pin_request_o, 1'b1)
        wr(IDX_IRQ_CLEAR, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            seed = xorshift(seed);
            v = seed[7:0];
            wr(IDX_COUNT, v);
            rdv(IDX_COUNT);
            `CHK(rd[7:0], v)
        end
        wr(IDX_MODE_CONTROL, 8'h70);
        repeat (20) @(posedge clk_i);
        rdv(IDX_COUNT);
        `CHK(rd[7:0], v)
        $display("test registers ended");
        wr(IDX_BASE_MODE, 8'h00);
        for (int r = 0; r < 8; r++)
        begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_MODE_CONTROL, 8'h80 | 8'(r << 4));
            repeat (4 * (256 >> r)) @(posedge clk_i);
            wr(IDX_MODE_CONTROL, 8'h00);
            rdv(IDX_COUNT);
            `CHK(in_rng(rd[7:0], 4, 6), 1'b1)
        end
        $display("test prescaler ended");
        for (int d = 0; d < 2; d++)
        begin
            wr(IDX_COUNT, 8'h00);
            wr(IDX_BASE_MODE, 8'h04 | 8'(d << 1));
            wr(IDX_MODE_CONTROL, 8'h80);
            evt_partner_i.send_ticks(20);
            wr(IDX_MODE_CONTROL, 8'h00);
            rdv(IDX_COUNT);
            `CHK(in_rng(rd[7:0], d ? 20 : 9, d ? 20 : 11), 1'b1)
        end
        wr(IDX_BASE_MODE, 8'h00);
        $display("test fast oscillator ended");
        seed = xorshift(seed);
        v = seed[7:0];
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_RELOAD_VALUE, v);
        wr(IDX_COUNT, 8'(256 - 3));
        wr(IDX_MODE_CONTROL, 8'hfe);
        evt_partner_i.pulse_events(2);
        rdv(IDX_COUNT);
        `CHK(rd[7:0], 8'hff)
        `CHK(overflow_request_o, 1'b0)
        `CHK(toggle_pin_oe_o, 1'b1)
        t0 = toggle_pin_o;
        evt_partner_i.pulse_events(1);
        rdv(IDX_COUNT);
        `CHK(rd[7:0], 8'h00)
        `CHK(overflow_request_o, 1'b1)
        `CHK(irq_o, 1'b1)
        `CHK(toggle_pin_o, ~t0)
        `CHK(edge_pin_request_o, 1'b0)
        wr(IDX_COUNT, 8'hff);
        evt_partner_i.pulse_events(1);
        rdv(IDX_COUNT);
        `CHK(rd[7:0], v)
        `CHK(toggle_pin_o, t0)
        wr(IDX_MODE_CONTROL, 8'hf8);
        wr(IDX_COUNT, 8'hff);
        evt_partner_i.pulse_events(1);
        rdv(IDX_COUNT);
        `CHK(rd[7:0], 8'h00)
        wr(IDX_IRQ_ENABLE, 8'h00);
        rdv(IDX_IRQ_STATUS);
        `CHK(rd[0], 1'b1)
        `CHK(irq_o, 1'b0)
        wr(IDX_IRQ_CLEAR, 8'h01);
        wr(IDX_MODE_CONTROL, 8'h00);
        rdv(IDX_IRQ_STATUS);
        `CHK(rd[0], 1'b0)
        `CHK(toggle_pin_oe_o, 1'b0)
        $display("test event counter ended");
        for (int c = 0; c < 4; c++)
        begin
            top = bnd_top(c);
            wr(IDX_RELOAD_VALUE, 8'h05);
            wr(IDX_COUNT, top);
            wr(IDX_MODE_CONTROL, 8'h89 | 8'(c << 1));
            evt_partner_i.pulse_events(1);
            rdv(IDX_COUNT);
            `CHK(rd[7:0], 8'h00)
            `CHK(overflow_request_o, 1'b1)
            `CHK(toggle_pin_oe_o, 1'b1)
            `CHK(toggle_pin_o, 1'b1)
            evt_partner_i.pulse_events(5);
            `CHK(toggle_pin_o, 1'b0)
            wr(IDX_MODE_CONTROL, 8'h00);
            wr(IDX_IRQ_CLEAR, 8'h01);
        end
        $display("test pwm ended");
        give_verdict();
    end
endmodule : event_timer_with_reload_tb_top
